// ===== inc/dpc_cfg.svh
// Offsets, field positions, reset values and timing counts of the disk chain controller
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH
// Command word indices and bits
`define DPC_CMD_WORDS 6
`define DPC_CW_CTRL 0
`define DPC_CW_BASE 1
`define DPC_CW_CHAIN 2
`define DPC_CW_MEM 3
`define DPC_CW_LBA 4
`define DPC_CW_COUNT 5
`define DPC_CB_GO 15
`define DPC_CB_END 14
`define DPC_CB_CHAIN 13
`define DPC_OP_READ 3'h0
`define DPC_OP_WRITE 3'h1
`define DPC_OP_FORMAT 3'h2
`define DPC_OP_RECAL 3'h3
// Parameter list
`define DPC_PRM_WORDS 8
`define DPC_PB_PX 6
`define DPC_PB_E 5
`define DPC_PB_S 4
`define DPC_PB_I 3
`define DPC_PB_NV 2
`define DPC_BASE_BAD 16'hfff1
// Status codes
`define DPC_ST_OK 4'h0
`define DPC_ST_ECC 4'h1
`define DPC_ST_DATA 4'h2
`define DPC_ST_IDNF 4'h3
`define DPC_ST_WPROT 4'h7
`define DPC_ST_CCW 4'h8
`define DPC_ST_FATAL_ABOVE 4'h2
// Timing (clock cycles at 10 MHz), ECC burst limit and protect shift
`define DPC_CLK_MHZ 10
`define DPC_ECC_MAX_BURST 4'hb
`define DPC_MMU_CYC 2'h3
`define DPC_BUF_SEEK_CYC 16'h0118
`define DPC_TK_QMS_SCALE 16
`define DPC_POST_INT_CYC 8'h64
`define DPC_POST_POLL_CYC 8'hc8
`define DPC_PROT_SHIFT 7
// Host register offsets
`define DPC_REG_CTRL 16'h0000
`define DPC_REG_ROOT 16'h0004
`define DPC_REG_STAT 16'h0008
`define DPC_REG_MEM 16'h0800
`define DPC_ROOT_RST 16'hfff0
`endif

// ===== inc/dpc_link_if.sv
// Shared system bus link between controller and host
`timescale 1ns/1ps
interface dpc_link_if;
  logic go;
  logic [15:0] root;
  logic busy;
  logic dma_req;
  logic dma_we;
  logic [15:0] dma_addr;
  logic [15:0] dma_wdata;
  logic dma_ack;
  logic [15:0] dma_rdata;
  logic mmu_sync;
  logic int_req;
  logic int_ack;
  logic [7:0] vect;
  logic vect_valid;
  modport dev (input go, root, dma_ack, dma_rdata, int_ack,
               output busy, dma_req, dma_we, dma_addr, dma_wdata, mmu_sync, int_req, vect,
               vect_valid);
  modport hst (output go, root, dma_ack, dma_rdata, int_ack,
               input busy, dma_req, dma_we, dma_addr, dma_wdata, mmu_sync, int_req, vect,
               vect_valid);
endinterface : dpc_link_if

// ===== inc/dpc_pkg.sv
// Types of the disk chain controller: the word shared by both ends and the controller-end state encoding
package dpc_pkg;
  typedef logic [15:0] dpc_word_t;
  typedef enum logic [3:0] {
    DPC_IDLE  = 4'h0,
    DPC_FETCH = 4'h1,
    DPC_PARAM = 4'h3,
    DPC_CHECK = 4'h2,
    DPC_CONV  = 4'h6,
    DPC_SEEK  = 4'h7,
    DPC_DISK  = 4'h5,
    DPC_WAITD = 4'h4,
    DPC_STAT  = 4'hc,
    DPC_INTR  = 4'hd,
    DPC_POST  = 4'hf
  } dpc_state_e;
endpackage : dpc_pkg

// ===== tb/disk_ctrl_param_chain_exec_tb.sv
// Self-checking bench: host end and controller end joined over the link
`timescale 1ns/1ps
module disk_ctrl_param_chain_exec_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [15:0] wb_adr = 16'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic wb_ack;
  logic disk_start, ecc_retx;
  logic done = 1'b0;
  logic idnf = 1'b0;
  logic nf_en = 1'b0;
  logic ecc = 1'b0;
  logic [3:0] burst = 4'h0;
  logic [1:0] drv, cap_drv;
  logic [3:0] head, cap_head;
  logic [15:0] cyl, cap_cyl, stat;
  logic [7:0] sec, cap_sec;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_start = 0;
  int n_retx = 0;
  int n_vec = 0;
  int n_prm = 0;
  always #50 clk_i = ~clk_i;
  dpc_link_if dpc_link_if_i ();
  dpc_host_end #(.MEM_WORDS(256)) dpc_host_end_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .link(dpc_link_if_i));
  dpc_dev_end dpc_dev_end_i (.clk_i(clk_i), .rst_i(rst_i), .link(dpc_link_if_i),
    .disk_start_o(disk_start), .disk_write_o(), .disk_format_o(), .drive_number_o(drv),
    .cyl_o(cyl), .head_o(head), .sector_o(sec), .ecc_retx_o(ecc_retx), .disk_done_i(done),
    .disk_id_nf_i(idnf), .disk_ecc_i(ecc), .ecc_burst_i(burst), .step_o(), .step_dir_o(),
    .reduced_write_current_out_o(), .early_o(), .late_o(), .shift_early_i(1'b0),
    .shift_late_i(1'b0), .format_gap_first_o(), .format_sync_o(), .format_gap_second_o());
  dpc_link_props dpc_link_props_i (.clk_i(clk_i), .rst_i(rst_i), .go(dpc_link_if_i.go),
    .root(dpc_link_if_i.root), .busy(dpc_link_if_i.busy), .dma_req(dpc_link_if_i.dma_req),
    .dma_we(dpc_link_if_i.dma_we), .dma_addr(dpc_link_if_i.dma_addr),
    .dma_ack(dpc_link_if_i.dma_ack), .mmu_sync(dpc_link_if_i.mmu_sync),
    .int_req(dpc_link_if_i.int_req), .int_ack(dpc_link_if_i.int_ack),
    .vect_valid(dpc_link_if_i.vect_valid));
  // Disk answers one cycle after each start; counters feed the scenario checks
  always @(posedge clk_i) begin
    done <= disk_start;
    // Defective track: only the alternate on cylinder 0 still holds the ID
    idnf <= nf_en && disk_start && cyl != 16'h0;
    if (disk_start === 1'b1) begin
      n_start++;
      cap_drv = drv;
      cap_head = head;
      cap_cyl = cyl;
      cap_sec = sec;
    end
    if (ecc_retx === 1'b1) n_retx++;
    if (dpc_link_if_i.vect_valid === 1'b1) n_vec++;
    if (dpc_link_if_i.dma_ack === 1'b1 && dpc_link_if_i.dma_we === 1'b0 &&
        dpc_link_if_i.dma_addr[15:6] === 10'h1) n_prm++;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Classic single cycle; no answer latency is assumed, only a bound
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack !== 1'b1 && t < 100);
    if (t >= 100) n_mismatch++;
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic mr(input logic [7:0] i);
    wb(1'b0, {6'h02, i, 2'b00}, 32'h0);
  endtask : mr
  task automatic blk(input logic [7:0] a, input logic [15:0] w [8], input int n);
    for (int k = 0; k < n; k++) begin
      wb(1'b1, {6'h02, a + 8'(k), 2'b00}, {16'h0, w[k]});
    end
  endtask : blk
  // Start at a root and poll the sticky done flag, then clear it
  task automatic run(input logic [15:0] r);
    int t;
    wb(1'b1, 16'h0004, {16'h0, r});
    wb(1'b1, 16'h0000, 32'h1);
    t = 0;
    do begin
      wb(1'b0, 16'h0008, 32'h0);
      t++;
    end while (rd[1] !== 1'b1 && t < 2000);
    if (t >= 2000) n_mismatch++;
    stat = rd[15:0];
    wb(1'b1, 16'h0008, 32'h2);
  endtask : run
  task automatic t_reset();
    wb(1'b0, 16'h0008, 32'h0);
    chk("status after reset", 16'h0, rd[15:0]);
    wb(1'b0, 16'h0004, 32'h0);
    chk("root after reset", 16'hfff0, rd[15:0]);
    wb(1'b1, 16'h0400, 32'hbeef);
    wb(1'b0, 16'h0400, 32'h0);
    chk("unmapped read", 16'h0, rd[15:0]);
  endtask : t_reset
  // Drive 2, four heads, 17 sectors: sector 158 sits on cylinder 2, head 1
  task automatic t_single();
    blk(8'h40, '{16'h000a, 16'h9d5a, 16'h0310, 0, 0, 0, 0, 0}, 8);
    blk(8'h10, '{16'hc000, 16'h0040, 0, 16'h0080, 16'h009e, 16'h0200, 0, 0}, 6);
    run(16'h0010);
    chk("vector status", 16'h5a06, stat & 16'hff06);
    mr(8'h10);
    chk("end status", 16'h4000, rd[15:0]);
    chk("param words", 16'd8, 16'(n_prm));
    chk("drive", 16'h2, {14'h0, cap_drv});
    chk("head", 16'h1, {12'h0, cap_head});
    chk("cylinder", 16'h2, cap_cyl);
    chk("sector", 16'h5, {8'h0, cap_sec});
    chk("vectors", 16'd1, 16'(n_vec));
  endtask : t_single
  // Corrected read, then a protected write ends the chain before the third
  task automatic t_chain();
    ecc <= 1'b1;
    burst <= 4'hb;
    blk(8'h50, '{16'h0029, 16'h9d33, 16'h0310, 0, 0, 0, 0, 16'h0001}, 8);
    blk(8'h20, '{16'ha000, 16'h0050, 16'h0030, 16'h0080, 16'h0200, 16'h0200, 0, 0}, 6);
    blk(8'h30, '{16'ha100, 16'h0050, 16'h0038, 16'h0080, 16'h0005, 16'h0200, 0, 0}, 6);
    blk(8'h38, '{16'hc000, 16'h0050, 0, 16'h0080, 16'h0200, 16'h0200, 0, 0}, 6);
    run(16'h0020);
    mr(8'h20);
    chk("corrected status", 16'h2001, rd[15:0]);
    mr(8'h30);
    chk("protect status", 16'h2107, rd[15:0]);
    mr(8'h38);
    chk("untouched command", 16'hc000, rd[15:0]);
    chk("param reload", 16'd16, 16'(n_prm));
    chk("disk starts", 16'd2, 16'(n_start));
    chk("retransfers", 16'd1, 16'(n_retx));
    chk("vectors", 16'd2, 16'(n_vec));
    ecc <= 1'b0;
  endtask : t_chain
  // Sync mode with a transfer crossing the top of the address space
  task automatic t_mmu();
    blk(8'h70, '{16'h0010, 16'h9d00, 16'h0310, 0, 0, 0, 0, 0}, 8);
    blk(8'h90, '{16'hc000, 16'h0070, 0, 16'hff00, 0, 16'h0200, 0, 0}, 6);
    run(16'h0090);
    mr(8'h90);
    chk("carry refused", 16'h4008, rd[15:0]);
    chk("no disk start", 16'd2, 16'(n_start));
    chk("no interrupt", 16'd2, 16'(n_vec));
  endtask : t_mmu
  // Missing ID: one track retry, then the alternate on cylinder 0 is found
  task automatic t_alt();
    nf_en <= 1'b1;
    blk(8'h60, '{16'h0000, 16'h9d00, 16'h1310, 16'h0100, 0, 0, 0, 0}, 8);
    blk(8'ha0, '{16'hc000, 16'h0060, 0, 16'h0080, 16'h009e, 16'h0200, 0, 0}, 6);
    run(16'h00a0);
    mr(8'ha0);
    chk("alternate status", 16'h4000, rd[15:0]);
    chk("retry starts", 16'd5, 16'(n_start));
    chk("alternate cylinder", 16'h0, cap_cyl);
    nf_en <= 1'b0;
  endtask : t_alt
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_chain();
    t_mmu();
    t_alt();
    print_verdict();
  end
  // The scenarios need a few thousand cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    print_verdict();
  end
endmodule : disk_ctrl_param_chain_exec_tb

// ===== tb/dpc_link_properties.sv
// Concurrent checks on the link between the host end and the controller end
`timescale 1ns/1ps
module dpc_link_props (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic go,
  input wire logic [15:0] root,
  input wire logic busy,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic dma_ack,
  input wire logic mmu_sync,
  input wire logic int_req,
  input wire logic int_ack,
  input wire logic vect_valid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic first_q;
  logic post_q;
  logic [15:0] post_cnt_q;
  // Armed by an accepted start, so the first fetch can be tied to root
  always_ff @(posedge clk_i) begin
    if (rst_i || dma_req) begin
      first_q <= 1'b0;
    end else if (go && !busy) begin
      first_q <= 1'b1;
    end
  end
  // Busy cycles after the acknowledge; length is only approximate, so a window
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) begin
      post_q <= 1'b0;
      post_cnt_q <= 16'h0;
    end else if (int_ack) begin
      post_q <= 1'b1;
      post_cnt_q <= 16'h0;
    end else begin
      post_cnt_q <= post_cnt_q + 16'h1;
    end
  end
  a_first_root: assert property (
    $rose(dma_req) && first_q |-> dma_addr == root)
    else $error("first fetch not at root");
  a_start_fetch: assert property (
    go && !busy |-> ##[1:20] dma_req)
    else $error("no fetch after start");
  a_plain_cycle: assert property (
    $rose(dma_req) && !mmu_sync |-> ##1 (dma_req && dma_ack) ##1 !dma_req)
    else $error("plain transfer timing wrong");
  a_mmu_four: assert property (
    $rose(dma_req) && mmu_sync |-> dma_req [*4] ##1 !dma_req)
    else $error("sync transfer not four clocks");
  a_req_steady: assert property (
    $rose(dma_req) |=> $stable(dma_addr) && $stable(dma_we))
    else $error("request changed before answer");
  a_mmu_one_ack: assert property (
    mmu_sync && dma_ack |=> !dma_ack [*3])
    else $error("sync transfer acknowledged twice");
  a_vec_after: assert property (
    vect_valid |-> $past(int_ack))
    else $error("vector without acknowledge");
  a_int_hold: assert property (
    int_req && !int_ack |=> int_req)
    else $error("interrupt dropped before acknowledge");
  a_int_busy: assert property (
    int_req |-> busy)
    else $error("interrupt while idle");
  a_post_len: assert property (
    $fell(busy) && post_q |-> post_cnt_q >= 16'd95 && post_cnt_q <= 16'd105)
    else $error("post processing length wrong");
endmodule : dpc_link_props

// ===== verilog/dpc_dev_end.sv
// Controller end: command chain fetch, parameter load, disk sequencing and status write-back
`timescale 1ns/1ps
`include "dpc_cfg.svh"
// Contract
// - Precomp enable gates early and late outputs
// - Correct bursts up to eleven bits, retransfer
// - MMU sync, four-clock DMA, refuse high carry
// - Interrupt only if enabled; vector when selected
// - Post-process busy 100 or 200 clocks
// - Host programs timer unit constant correctly
// - Drive, heads and sectors drive address conversion
// - Track retries, then recalibrate retries
// - Retry only for the allowed error combinations
// - Step period from field; zero is buffered
// - Format uses gap and sync fields
// - Reduced current and precomp above thresholds
// - Refuse writes below protect limit
// - ID not found searches alternate cylinders
// - Host prepares alternate tracks and count
// - Every start begins at root address
// - Fetch first command, check format first
// - Write status, then follow chain
// - Status above two is fatal, ends chain
// - Reload parameters only on new base
// - End bit finishes chain with interrupt; the code raises it only when the I bit of the parameters is set
// - Host polls or waits interrupt, checks status
// - Parameters are eight words from base
module dpc_dev_end import dpc_pkg::*; (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Host link
  dpc_link_if.dev link,
  // Disk operation request
  output logic disk_start_o,
  output logic disk_write_o,
  output logic disk_format_o,
  output logic [1:0] drive_number_o,
  output logic [15:0] cyl_o,
  output logic [3:0] head_o,
  output logic [7:0] sector_o,
  output logic ecc_retx_o,
  // Disk operation result
  input wire logic disk_done_i,
  input wire logic disk_id_nf_i,
  input wire logic disk_ecc_i,
  input wire logic [3:0] ecc_burst_i,
  // Drive control
  output logic step_o,
  output logic step_dir_o,
  output logic reduced_write_current_out_o,
  output logic early_o,
  output logic late_o,
  input wire logic shift_early_i,
  input wire logic shift_late_i,
  // Format fields
  output logic [5:0] format_gap_first_o,
  output logic [3:0] format_sync_o,
  output logic [2:0] format_gap_second_o
);
  dpc_state_e st_q;
  dpc_word_t cmd_q [`DPC_CMD_WORDS];
  dpc_word_t prm_q [`DPC_PRM_WORDS];
  logic [2:0] idx_q;
  logic req_q;
  logic we_q;
  logic [15:0] addr_q;
  dpc_word_t wdata_q;
  logic [1:0] cyc_q;
  logic got_ack_q;
  logic [15:0] cur_q;
  logic [15:0] last_base_q;
  logic base_ok_q;
  logic [3:0] status_q;
  logic [15:0] rem_q;
  logic [15:0] trk_q;
  logic conv_ph_q;
  logic [15:0] pos_q;
  logic [15:0] tgt_q;
  logic [15:0] tmr_q;
  logic recal_q;
  logic alt_q;
  logic [3:0] r1_q;
  logic [3:0] r2_q;
  logic [7:0] post_q;
  logic start_q;
  logic retx_q;
  logic step_q;
  logic vv_q;
  logic [7:0] vec_q;
  logic dma_done;
  logic mmu;
  logic [2:0] op;
  logic [15:0] period;
  logic fail_rt;
  logic ecc_fix;
  logic [16:0] mem_end;
  assign mmu = prm_q[0][`DPC_PB_S];
  assign op = cmd_q[`DPC_CW_CTRL][10:8];
  // Memory transfer end; a carry out of the low 16 bits would need a high-address change
  assign mem_end = {1'b0, cmd_q[`DPC_CW_MEM]} + {1'b0, cmd_q[`DPC_CW_COUNT]};
  assign dma_done = req_q && (link.dma_ack || got_ack_q) && (!mmu || cyc_q == `DPC_MMU_CYC);
  // Quarter millisecond is the timer unit constant times 16 clocks
  assign period = (prm_q[3][3:0] == 4'h0) ? `DPC_BUF_SEEK_CYC :
                  16'(prm_q[3][3:0] * prm_q[1][15:8] * `DPC_TK_QMS_SCALE);
  assign ecc_fix = disk_ecc_i && prm_q[0][`DPC_PB_E] && ecc_burst_i <= `DPC_ECC_MAX_BURST;
  assign fail_rt = (!prm_q[0][`DPC_PB_E] && disk_id_nf_i) ||
                   (prm_q[0][`DPC_PB_E] && disk_ecc_i && disk_id_nf_i);

  assign link.busy = st_q != DPC_IDLE;
  assign link.dma_req = req_q;
  assign link.dma_we = we_q;
  assign link.dma_addr = addr_q;
  assign link.dma_wdata = wdata_q;
  assign link.mmu_sync = req_q && mmu;
  assign link.int_req = st_q == DPC_INTR;
  assign link.vect = vec_q;
  assign link.vect_valid = vv_q;
  assign disk_start_o = start_q;
  assign ecc_retx_o = retx_q;
  assign step_o = step_q;
  assign drive_number_o = prm_q[0][1:0];
  assign cyl_o = tgt_q;
  assign disk_write_o = op == `DPC_OP_WRITE;
  assign disk_format_o = op == `DPC_OP_FORMAT;
  assign format_gap_first_o = prm_q[4][15:10];
  assign format_sync_o = prm_q[4][9:6];
  assign format_gap_second_o = prm_q[4][5:3];
  assign reduced_write_current_out_o = pos_q > {6'h0, prm_q[5][9:0]};
  assign early_o = prm_q[0][`DPC_PB_PX] && disk_write_o && pos_q > {6'h0, prm_q[6][9:0]}
                   && shift_early_i;
  assign late_o = prm_q[0][`DPC_PB_PX] && disk_write_o && pos_q > {6'h0, prm_q[6][9:0]}
                  && shift_late_i;

  // DMA handshake: request held until acknowledged and, in MMU mode, four clocks long
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_q <= 2'h0;
      got_ack_q <= 1'b0;
    end else if (!req_q || dma_done) begin
      cyc_q <= 2'h0;
      got_ack_q <= 1'b0;
    end else begin
      if (cyc_q != `DPC_MMU_CYC) cyc_q <= cyc_q + 2'h1;
      if (link.dma_ack) got_ack_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= DPC_IDLE;
      idx_q <= 3'h0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0;
      wdata_q <= 16'h0;
      cur_q <= 16'h0;
      last_base_q <= 16'h0;
      base_ok_q <= 1'b0;
      status_q <= `DPC_ST_OK;
      rem_q <= 16'h0;
      trk_q <= 16'h0;
      conv_ph_q <= 1'b0;
      tgt_q <= 16'h0;
      recal_q <= 1'b0;
      alt_q <= 1'b0;
      r1_q <= 4'h0;
      r2_q <= 4'h0;
      post_q <= 8'h0;
      start_q <= 1'b0;
      retx_q <= 1'b0;
      vv_q <= 1'b0;
      vec_q <= 8'h0;
      head_o <= 4'h0;
      sector_o <= 8'h0;
      for (int i = 0; i < `DPC_CMD_WORDS; i++) cmd_q[i] <= 16'h0;
      for (int i = 0; i < `DPC_PRM_WORDS; i++) prm_q[i] <= 16'h0;
    end else begin
      start_q <= 1'b0;
      retx_q <= 1'b0;
      vv_q <= 1'b0;
      unique case (st_q)
        DPC_IDLE: begin
          if (link.go) begin
            cur_q <= link.root;
            idx_q <= 3'h0;
            st_q <= DPC_FETCH;
          end
        end
        DPC_FETCH: begin
          if (!req_q) begin
            req_q <= 1'b1;
            we_q <= 1'b0;
            addr_q <= cur_q + {13'h0, idx_q};
          end else if (dma_done) begin
            req_q <= 1'b0;
            cmd_q[idx_q] <= link.dma_rdata;
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(`DPC_CMD_WORDS - 1)) begin
              idx_q <= 3'h0;
              r1_q <= 4'h0;
              r2_q <= 4'h0;
              alt_q <= 1'b0;
              recal_q <= 1'b0;
              if (cmd_q[`DPC_CW_BASE] >= `DPC_BASE_BAD) begin
                status_q <= `DPC_ST_CCW;
                st_q <= DPC_STAT;
              end else if (!base_ok_q || cmd_q[`DPC_CW_BASE] != last_base_q) begin
                st_q <= DPC_PARAM;
              end else begin
                st_q <= DPC_CHECK;
              end
            end
          end
        end
        DPC_PARAM: begin
          if (!req_q) begin
            req_q <= 1'b1;
            we_q <= 1'b0;
            addr_q <= cmd_q[`DPC_CW_BASE] + {13'h0, idx_q};
          end else if (dma_done) begin
            req_q <= 1'b0;
            prm_q[idx_q] <= link.dma_rdata;
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(`DPC_PRM_WORDS - 1)) begin
              last_base_q <= cmd_q[`DPC_CW_BASE];
              base_ok_q <= 1'b1;
              st_q <= DPC_CHECK;
            end
          end
        end
        DPC_CHECK: begin
          rem_q <= cmd_q[`DPC_CW_LBA];
          trk_q <= 16'h0;
          tgt_q <= 16'h0;
          conv_ph_q <= 1'b0;
          if (op > `DPC_OP_RECAL || (mmu && mem_end[16])) begin
            status_q <= `DPC_ST_CCW;
            st_q <= DPC_STAT;
          end else if (op == `DPC_OP_WRITE &&
                       {7'h0, cmd_q[`DPC_CW_LBA]} < {prm_q[7][15:0], 7'h0}) begin
            status_q <= `DPC_ST_WPROT;
            st_q <= DPC_STAT;
          end else begin
            st_q <= DPC_CONV;
          end
        end
        DPC_CONV: begin
          // Serial division keeps the converter small; one clock per track and per cylinder counted off
          if (!conv_ph_q) begin
            if (rem_q > {8'h0, prm_q[2][7:0]}) begin
              rem_q <= rem_q - {8'h0, prm_q[2][7:0]} - 16'h1;
              trk_q <= trk_q + 16'h1;
            end else begin
              conv_ph_q <= 1'b1;
            end
          end else if (trk_q > {12'h0, prm_q[2][11:8]}) begin
            trk_q <= trk_q - {12'h0, prm_q[2][11:8]} - 16'h1;
            tgt_q <= tgt_q + 16'h1;
          end else begin
            sector_o <= rem_q[7:0];
            head_o <= trk_q[3:0];
            if (op == `DPC_OP_RECAL) tgt_q <= 16'h0;
            st_q <= DPC_SEEK;
          end
        end
        DPC_SEEK: begin
          if (pos_q == (recal_q ? 16'h0 : tgt_q)) begin
            if (recal_q) begin
              recal_q <= 1'b0;
            end else if (op == `DPC_OP_RECAL) begin
              status_q <= `DPC_ST_OK;
              st_q <= DPC_STAT;
            end else begin
              st_q <= DPC_DISK;
            end
          end
        end
        DPC_DISK: begin
          start_q <= 1'b1;
          st_q <= DPC_WAITD;
        end
        DPC_WAITD: begin
          if (disk_done_i) begin
            if (ecc_fix && !disk_id_nf_i) begin
              retx_q <= 1'b1;
              status_q <= `DPC_ST_ECC;
              st_q <= DPC_STAT;
            end else if (!disk_ecc_i && !disk_id_nf_i) begin
              status_q <= `DPC_ST_OK;
              st_q <= DPC_STAT;
            end else if (alt_q && disk_id_nf_i && tgt_q < {12'h0, prm_q[2][15:12]}) begin
              tgt_q <= tgt_q + 16'h1;
              st_q <= DPC_SEEK;
            end else if (!alt_q && fail_rt && r1_q < prm_q[3][11:8]) begin
              r1_q <= r1_q + 4'h1;
              st_q <= DPC_DISK;
            end else if (!alt_q && fail_rt && r2_q < prm_q[3][7:4]) begin
              r2_q <= r2_q + 4'h1;
              r1_q <= 4'h0;
              recal_q <= 1'b1;
              st_q <= DPC_SEEK;
            end else if (!alt_q && disk_id_nf_i && prm_q[2][15:12] != 4'h0) begin
              alt_q <= 1'b1;
              tgt_q <= 16'h0;
              st_q <= DPC_SEEK;
            end else begin
              status_q <= disk_id_nf_i ? `DPC_ST_IDNF : `DPC_ST_DATA;
              st_q <= DPC_STAT;
            end
          end
        end
        DPC_STAT: begin
          if (!req_q) begin
            req_q <= 1'b1;
            we_q <= 1'b1;
            addr_q <= cur_q;
            wdata_q <= {1'b0, cmd_q[`DPC_CW_CTRL][14:4], status_q};
          end else if (dma_done) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            idx_q <= 3'h0;
            if (status_q > `DPC_ST_FATAL_ABOVE || cmd_q[`DPC_CW_CTRL][`DPC_CB_END] ||
                !cmd_q[`DPC_CW_CTRL][`DPC_CB_CHAIN]) begin
              // Interrupt-driven end needs 100 clocks after acknowledge, polling 200
              post_q <= `DPC_POST_POLL_CYC;
              st_q <= prm_q[0][`DPC_PB_I] ? DPC_INTR : DPC_POST;
            end else begin
              cur_q <= cmd_q[`DPC_CW_CHAIN];
              st_q <= DPC_FETCH;
            end
          end
        end
        DPC_INTR: begin
          if (link.int_ack) begin
            vv_q <= !prm_q[0][`DPC_PB_NV];
            vec_q <= prm_q[1][7:0];
            post_q <= `DPC_POST_INT_CYC;
            st_q <= DPC_POST;
          end
        end
        DPC_POST: begin
          post_q <= post_q - 8'h1;
          if (post_q == 8'h1) st_q <= DPC_IDLE;
        end
        default: st_q <= DPC_IDLE;
      endcase
    end
  end

  // Head stepping toward the current seek goal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 16'h0;
      tmr_q <= 16'h0;
      step_q <= 1'b0;
      step_dir_o <= 1'b0;
    end else begin
      step_q <= 1'b0;
      if (st_q != DPC_SEEK) begin
        tmr_q <= 16'h0;
      end else if (tmr_q != 16'h0) begin
        tmr_q <= tmr_q - 16'h1;
      end else if (pos_q != (recal_q ? 16'h0 : tgt_q)) begin
        step_q <= 1'b1;
        step_dir_o <= pos_q < (recal_q ? 16'h0 : tgt_q);
        pos_q <= (pos_q < (recal_q ? 16'h0 : tgt_q)) ? pos_q + 16'h1 : pos_q - 16'h1;
        tmr_q <= period - 16'h1;
      end
    end
  end
endmodule : dpc_dev_end

// ===== verilog/dpc_host_end.sv
// Host end: Wishbone register slave, shared memory and interrupt acknowledge
`timescale 1ns/1ps
`include "dpc_cfg.svh"
module dpc_host_end import dpc_pkg::*; #(
  parameter int MEM_WORDS = 256
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link
  dpc_link_if.hst link
);
  localparam int AW = $clog2(MEM_WORDS);
  dpc_word_t mem [MEM_WORDS];
  logic ack_q;
  logic [31:0] dat_q;
  logic go_q;
  logic [15:0] root_q;
  logic done_q;
  logic busy_q;
  logic [7:0] vec_q;
  logic vec_ok_q;
  logic dack_q;
  dpc_word_t drd_q;
  logic iack_q;
  logic dreq_q;
  logic req_w;
  logic is_mem;
  assign req_w = wb_cyc_i && wb_stb_i && !ack_q;
  assign is_mem = wb_adr_i >= `DPC_REG_MEM;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign link.go = go_q;
  assign link.root = root_q;
  assign link.dma_ack = dack_q;
  assign link.dma_rdata = drd_q;
  assign link.int_ack = iack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req_w;
      dat_q <= 32'h0;
      if (req_w && !wb_we_i) begin
        if (is_mem) begin
          dat_q <= {16'h0, mem[wb_adr_i[AW+1:2]]};
        end else if (wb_adr_i == `DPC_REG_ROOT) begin
          dat_q <= {16'h0, root_q};
        end else if (wb_adr_i == `DPC_REG_STAT) begin
          dat_q <= {16'h0, vec_q, 5'h0, vec_ok_q, done_q, busy_q};
        end
      end
    end
  end

  // Memory is shared: software fills command chains, the controller reads and writes by DMA
  always_ff @(posedge clk_i) begin
    if (req_w && wb_we_i && is_mem) begin
      if (wb_sel_i[0]) mem[wb_adr_i[AW+1:2]][7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) mem[wb_adr_i[AW+1:2]][15:8] <= wb_dat_i[15:8];
    end
    if (link.dma_req && link.dma_we && !dreq_q) begin
      mem[link.dma_addr[AW-1:0]] <= link.dma_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dack_q <= 1'b0;
      dreq_q <= 1'b0;
      drd_q <= 16'h0;
    end else begin
      // One acknowledge per request; a long sync-mode request must not be taken twice
      dreq_q <= link.dma_req;
      dack_q <= link.dma_req && !dreq_q;
      drd_q <= mem[link.dma_addr[AW-1:0]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_q <= 1'b0;
      root_q <= `DPC_ROOT_RST;
    end else begin
      go_q <= req_w && wb_we_i && wb_adr_i == `DPC_REG_CTRL && wb_sel_i[0] && wb_dat_i[0];
      if (req_w && wb_we_i && wb_adr_i == `DPC_REG_ROOT && wb_sel_i[1:0] == 2'h3) begin
        root_q <= wb_dat_i[15:0];
      end
    end
  end

  // Done is sticky; a busy fall in the same cycle as a clear keeps it set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      iack_q <= 1'b0;
      vec_q <= 8'h0;
      vec_ok_q <= 1'b0;
    end else begin
      busy_q <= link.busy;
      iack_q <= link.int_req && !iack_q;
      if (busy_q && !link.busy) begin
        done_q <= 1'b1;
      end else if (req_w && wb_we_i && wb_adr_i == `DPC_REG_STAT && wb_dat_i[1]) begin
        done_q <= 1'b0;
      end
      if (link.vect_valid) begin
        vec_q <= link.vect;
        vec_ok_q <= 1'b1;
      end else if (link.go) begin
        vec_ok_q <= 1'b0;
      end
    end
  end
endmodule : dpc_host_end
